// [hdl/stc_pkg.sv]
/*
  Shared constants for the synchronous DRAM device core: command encodings,
  mode-word fields, reset values and the fixed cycle latencies.
  Assumes a single rising-edge clock domain shared with the controller.
*/
package stc_pkg;

  // gray along idle -> read -> write -> self refresh
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_READ    = 2'b01,
    ST_WRITE   = 2'b11,
    ST_SELFREF = 2'b10
  } stc_state_type;

  // {row strobe, column strobe, write enable}, all active low, chip selected
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_BSTOP = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  localparam int ADDR_W = 13;
  localparam int AP_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_LAT_LSB = 4;
  localparam int MR_FIELD_W = 3;
  localparam int BURST_CNT_W = 4;

  localparam logic [2:0] BL_CODE_RESET = 3'h0;
  localparam logic [2:0] LAT_RESET = 3'h2;
  localparam logic [2:0] LAT_THREE = 3'h3;

  // fixed latencies in clock cycles
  localparam int COLUMN_TO_COLUMN_DELAY = 1;
  localparam int CLOCK_GATE_ENTRY_LATENCY = 1;
  localparam int CLOCK_GATE_EXIT_LATENCY = 1;
  localparam int MASK_TO_WRITE_BLOCK_DELAY = 0;
  localparam int MASK_TO_OUTPUT_FLOAT_DELAY = 2;
  localparam int PRECHARGE_TO_OUTPUT_FLOAT_LAT3 = 3;
  localparam int PRECHARGE_TO_OUTPUT_FLOAT_LAT2 = 2;

  localparam int READ_PIPE_DEPTH = 2;
  localparam int COPY_FIFO_DEPTH = 2;

endpackage

// [hdl/stc_fifo.sv]
/*
  Small first-word-fall-through buffer with valid/ready on both sides.
  The head entry is always slot zero, so the output data is a flip-flop.
  Assumes in_valid is only raised while in_ready is high.
*/
`timescale 1ns/1ps
module stc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [WIDTH-1:0] ent_reg [DEPTH];
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
  assign out_data = ent_reg[0];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      count_reg <= count_next;
      out_valid <= count_next != '0;
      in_ready <= count_next != CNT_W'(DEPTH);
    end
  end

  // no reset on the data slots: valid gates them
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop) begin
        if (push && (CNT_W'(i) == count_reg - CNT_W'(1))) begin
          ent_reg[i] <= in_data;
        end else if (i < DEPTH - 1) begin
          ent_reg[i] <= ent_reg[i + 1];
        end
      end else if (push && (CNT_W'(i) == count_reg)) begin
        ent_reg[i] <= in_data;
      end
    end
  end

endmodule

// [hdl/stc_device.sv]
/*
  Core of a four-bank synchronous DRAM: command decode, burst engine,
  clock-enable gating, data masking and read-data pipeline, with a copy of
  every driven read word offered on a buffered stream.
  Assumes the controller runs on sys_clk and keeps its own spacing limits.
*/
// Contract
// - column commands may come on consecutive clocks, one cycle apart
// - clock enable low suspends clocking or enters power-down one clock later
// - clock enable high resumes clocking or leaves power-down one clock later
// - write mask applies to the data word on the same edge
// - masked write word is not stored, zero cycles latency
// - read mask floats the data outputs two clocks later
// - precharge during read floats outputs after read latency clocks
`timescale 1ns/1ps
module stc_device #(
  parameter int DATA_W = 8,
  parameter int BANK_W = 2,
  parameter int ROW_W = 2,
  parameter int COL_W = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // command inputs from the controller
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] bank,
  input wire logic [stc_pkg::ADDR_W-1:0] addr,
  // data pin and mask
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic dqm,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  // copy of driven read words
  output logic [DATA_W-1:0] rd_copy_data,
  output logic rd_copy_valid,
  input wire logic rd_copy_ready,
  // status
  output logic pdown,
  output logic suspended,
  output logic self_refresh
);
  localparam int IDX_W = BANK_W + ROW_W + COL_W;
  localparam int WORDS = 2 ** IDX_W;
  localparam int BANKS = 2 ** BANK_W;
  localparam int BC_W = stc_pkg::BURST_CNT_W;

  function automatic logic [IDX_W-1:0] word_idx(input logic [BANK_W-1:0] b,
      input logic [ROW_W-1:0] r, input logic [COL_W-1:0] c);
    return {b, r, c};
  endfunction

  function automatic logic [BC_W-1:0] burst_len(input logic [2:0] code);
    case (code)
      3'h0: return BC_W'(1);
      3'h1: return BC_W'(2);
      3'h2: return BC_W'(4);
      default: return BC_W'(8);
    endcase
  endfunction

  stc_pkg::stc_state_type state_reg;
  logic cke_reg;
  logic buf_in_ready;
  logic run;
  logic [2:0] cmd;
  logic is_act, is_rd, is_wr, is_bst, is_pre, is_ref, is_mode;
  logic pre_hit, stop, cont, col_cmd, last_cont;
  logic [BANK_W-1:0] burst_bank_reg;
  logic [ROW_W-1:0] burst_row_reg;
  logic [COL_W-1:0] burst_col_reg;
  logic [BC_W-1:0] burst_left_reg;
  logic burst_ap_reg;
  logic [2:0] bl_code_reg;
  logic [2:0] lat_reg;
  logic [ROW_W-1:0] row_addr_reg [BANKS];
  logic [BANKS-1:0] row_open_reg;
  logic [DATA_W-1:0] mem_reg [WORDS];
  logic [IDX_W-1:0] cur_idx;
  logic [COL_W-1:0] cur_col;
  logic [DATA_W-1:0] wr_old;
  logic rd_word, wr_word, wr_store;
  localparam int READ_PIPE_DEPTH_M1 = stc_pkg::READ_PIPE_DEPTH - 1;
  logic [READ_PIPE_DEPTH_M1:0] pipe_v_reg;
  logic [DATA_W-1:0] pipe_d_reg [stc_pkg::READ_PIPE_DEPTH];
  logic mask_reg;
  logic sel_v;
  logic [DATA_W-1:0] sel_d;
  logic busy;

  // a full copy buffer freezes the core like a clock suspend, so no word is lost
  assign run = cke_reg & buf_in_ready;
  assign cmd = cs_n ? stc_pkg::CMD_NOP : {ras_n, cas_n, we_n};
  assign is_act = run && (cmd == stc_pkg::CMD_ACT);
  assign is_rd = run && (cmd == stc_pkg::CMD_READ) && row_open_reg[bank];
  assign is_wr = run && (cmd == stc_pkg::CMD_WRITE) && row_open_reg[bank];
  assign is_bst = run && (cmd == stc_pkg::CMD_BSTOP);
  assign is_pre = run && (cmd == stc_pkg::CMD_PRE);
  assign is_ref = run && (cmd == stc_pkg::CMD_REFRESH);
  assign is_mode = run && (cmd == stc_pkg::CMD_MODE);
  assign col_cmd = is_rd | is_wr;
  assign pre_hit = is_pre && (addr[stc_pkg::AP_BIT] || bank == burst_bank_reg);
  assign stop = is_bst | pre_hit;
  assign cont = run && (state_reg == stc_pkg::ST_READ || state_reg == stc_pkg::ST_WRITE)
      && burst_left_reg != '0 && !stop && !col_cmd;
  assign last_cont = cont && burst_left_reg == BC_W'(1);
  assign cur_col = col_cmd ? addr[COL_W-1:0] : burst_col_reg;
  assign cur_idx = col_cmd ? word_idx(bank, row_addr_reg[bank], cur_col)
      : word_idx(burst_bank_reg, burst_row_reg, cur_col);
  assign rd_word = is_rd || (cont && state_reg == stc_pkg::ST_READ);
  assign wr_word = is_wr || (cont && state_reg == stc_pkg::ST_WRITE);
  assign wr_store = wr_word && !dqm;
  assign wr_old = mem_reg[cur_idx];
  assign sel_v = (lat_reg == stc_pkg::LAT_THREE) ? pipe_v_reg[1] : pipe_v_reg[0];
  assign sel_d = (lat_reg == stc_pkg::LAT_THREE) ? pipe_d_reg[1] : pipe_d_reg[0];
  assign busy = (state_reg == stc_pkg::ST_READ) || (state_reg == stc_pkg::ST_WRITE)
      || (|pipe_v_reg);

  // level sampled at one edge gates the next edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cke_reg <= 1'b1;
    end else begin
      cke_reg <= cke;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= stc_pkg::ST_IDLE;
      burst_bank_reg <= '0;
      burst_row_reg <= '0;
      burst_col_reg <= '0;
      burst_left_reg <= '0;
      burst_ap_reg <= 1'b0;
      self_refresh <= 1'b0;
    end else if (state_reg == stc_pkg::ST_SELFREF) begin
      if (cke_reg) begin
        state_reg <= stc_pkg::ST_IDLE;
        self_refresh <= 1'b0;
      end
    end else if (col_cmd) begin
      state_reg <= (burst_len(bl_code_reg) == BC_W'(1)) ? stc_pkg::ST_IDLE
          : (is_rd ? stc_pkg::ST_READ : stc_pkg::ST_WRITE);
      burst_bank_reg <= bank;
      burst_row_reg <= row_addr_reg[bank];
      burst_col_reg <= cur_col + COL_W'(1);
      burst_left_reg <= burst_len(bl_code_reg) - BC_W'(1);
      burst_ap_reg <= addr[stc_pkg::AP_BIT];
    end else if (stop) begin
      state_reg <= stc_pkg::ST_IDLE;
      burst_left_reg <= '0;
    end else if (cont) begin
      burst_col_reg <= burst_col_reg + COL_W'(1);
      burst_left_reg <= burst_left_reg - BC_W'(1);
      if (last_cont) begin
        state_reg <= stc_pkg::ST_IDLE;
      end
    end else if (is_ref && !cke) begin
      state_reg <= stc_pkg::ST_SELFREF;
      self_refresh <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bl_code_reg <= stc_pkg::BL_CODE_RESET;
      lat_reg <= stc_pkg::LAT_RESET;
    end else if (is_mode) begin
      bl_code_reg <= addr[stc_pkg::MR_BL_LSB +: stc_pkg::MR_FIELD_W];
      lat_reg <= addr[stc_pkg::MR_LAT_LSB +: stc_pkg::MR_FIELD_W];
    end
  end

  // open rows per bank gate column commands; auto precharge closes on the last word
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      row_open_reg <= '0;
      for (int b = 0; b < BANKS; b++) begin
        row_addr_reg[b] <= '0;
      end
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        if (is_act && bank == BANK_W'(b)) begin
          row_open_reg[b] <= 1'b1;
          row_addr_reg[b] <= addr[ROW_W-1:0];
        end else if (is_pre && (addr[stc_pkg::AP_BIT] || bank == BANK_W'(b))) begin
          row_open_reg[b] <= 1'b0;
        end else if (last_cont && burst_ap_reg && burst_bank_reg == BANK_W'(b)) begin
          row_open_reg[b] <= 1'b0;
        end else if (col_cmd && addr[stc_pkg::AP_BIT] && bank == BANK_W'(b)
            && burst_len(bl_code_reg) == BC_W'(1)) begin
          row_open_reg[b] <= 1'b0;
        end
      end
    end
  end

  // array has no reset, as in the real part
  always_ff @(posedge sys_clk) begin
    if (wr_store) begin
      mem_reg[cur_idx] <= dq_in;
    end
  end

  // words leave the pipeline already generated, so a precharge only stops new ones
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pipe_v_reg <= '0;
      mask_reg <= 1'b0;
      dq_oe <= 1'b0;
      dq_out <= '0;
      for (int i = 0; i < stc_pkg::READ_PIPE_DEPTH; i++) begin
        pipe_d_reg[i] <= '0;
      end
    end else if (run) begin
      pipe_v_reg <= {pipe_v_reg[0], rd_word};
      pipe_d_reg[0] <= wr_old;
      pipe_d_reg[1] <= pipe_d_reg[0];
      mask_reg <= dqm;
      dq_oe <= sel_v & ~mask_reg;
      dq_out <= sel_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pdown <= 1'b0;
      suspended <= 1'b0;
    end else begin
      pdown <= !cke && !busy;
      suspended <= !cke && busy;
    end
  end

  stc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(stc_pkg::COPY_FIFO_DEPTH)
  ) copy_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(run & sel_v & ~mask_reg),
    .in_ready(buf_in_ready),
    .in_data(sel_d),
    .out_valid(rd_copy_valid),
    .out_ready(rd_copy_ready),
    .out_data(rd_copy_data)
  );

  back_to_back_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (is_rd ##1 is_rd) |=> (pipe_v_reg[0] && $past(pipe_v_reg[0])))
    else $error("consecutive reads did not both start a word");

  gate_entry_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !cke |=> !run)
    else $error("core ran one clock after clock enable went low");

  gate_exit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cke ##1 buf_in_ready) |-> run)
    else $error("core did not resume one clock after clock enable high");

  write_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_store |=> mem_reg[$past(cur_idx)] == $past(dq_in))
    else $error("unmasked write word not stored on its edge");

  write_block_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_word && dqm) |=> mem_reg[$past(cur_idx)] == $past(wr_old))
    else $error("masked write word changed the array");

  read_mask_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (run && dqm) ##1 run |=> !dq_oe)
    else $error("read mask did not float outputs two clocks later");

  pre_float_lat3_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (pre_hit && !col_cmd && lat_reg == stc_pkg::LAT_THREE) ##1 (run && !is_rd)[*2]
    |=> !dq_oe)
    else $error("outputs still driven three clocks after precharge");

  pre_float_lat2_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (pre_hit && !col_cmd && lat_reg == stc_pkg::LAT_RESET) ##1 (run && !is_rd)
    |=> !dq_oe)
    else $error("outputs still driven two clocks after precharge");

endmodule

// [verification/stc_ctrl_model.sv]
/*
  Controller-side model: drives clock enable, command, address, data and mask.
  Assumes its tasks are called at the falling clock edge, one at a time.
*/
`timescale 1ns/1ps
module stc_ctrl_model (
  // clock
  input wire logic sys_clk,
  // command and address
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd,
  output logic [12:0] addr,
  // write data
  output logic [7:0] dq_in,
  output logic dqm
);
  localparam int CLK_NS = 50;
  localparam int ACT_GAP = (20 + CLK_NS - 1) / CLK_NS;
  localparam int RFC_GAP = (66 + CLK_NS - 1) / CLK_NS;
  localparam int SR_GAP = 2;
  int since_wr = 99;

  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    cmd = stc_pkg::CMD_NOP;
    addr = 13'h0;
    dq_in = 8'h0;
    dqm = 1'b0;
  end

  task automatic step();
    @(negedge sys_clk);
    since_wr++;
  endtask

  // a released data line toggles so a stale word never looks valid
  task automatic nop(input int n);
    repeat (n) begin
      cs_n = 1'b1;
      dq_in = ~dq_in;
      dqm = 1'b0;
      step();
    end
  endtask

  task automatic send(input logic [2:0] c, input logic [12:0] a, input logic [7:0] d,
                      input logic m);
    cs_n = 1'b0;
    cmd = c;
    addr = a;
    dq_in = (c == stc_pkg::CMD_WRITE) ? d : ~dq_in;
    dqm = m;
    if (c == stc_pkg::CMD_WRITE) since_wr = -1;
    step();
  endtask

  task automatic word(input logic [7:0] d, input logic m);
    cs_n = 1'b1;
    dq_in = d;
    dqm = m;
    since_wr = -1;
    step();
  endtask

  task automatic en(input logic v);
    cke = v;
  endtask

  // recovery is counted from the last data edge, so waits are conservative
  task automatic act(input logic [12:0] row);
    while (since_wr < 4) nop(1);
    send(stc_pkg::CMD_ACT, row, 8'h0, 1'b0);
    nop(ACT_GAP - 1);
  endtask

  task automatic pre(input logic [12:0] a);
    while (since_wr < 1) nop(1);
    send(stc_pkg::CMD_PRE, a, 8'h0, 1'b0);
  endtask

  task automatic mode(input logic [12:0] a);
    send(stc_pkg::CMD_MODE, a, 8'h0, 1'b0);
    nop(1);
  endtask

  task automatic refresh();
    send(stc_pkg::CMD_REFRESH, 13'h0, 8'h0, 1'b0);
    nop(RFC_GAP);
  endtask

  task automatic sr_exit();
    cke = 1'b1;
    nop(SR_GAP);
  endtask
endmodule

// [verification/tb_top.sv]
/*
  Self-checking bench for the DRAM device core driven by the controller model.
  Assumes the core's default widths; bank is driven here and mostly left at zero.
*/
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [2:0] col;
    logic [7:0] wd;
    logic mask;
    logic [7:0] want;
  } stc_row_type;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic rd_copy_ready = 1'b1;
  logic [1:0] bank = 2'h0;
  logic cke, cs_n, dqm, dq_oe, rd_copy_valid, pdown, suspended, self_refresh;
  logic [2:0] cmd;
  logic [12:0] addr;
  logic [7:0] dq_in, dq_out, rd_copy_data;
  logic [7:0] mem [8];
  logic [7:0] got [$];
  int n_mismatch = 0;
  int n_checks = 0;
  // last row is masked and must leave the earlier word of column one
  stc_row_type rows [9] = '{
    '{3'h0, 8'h11, 1'b0, 8'h11}, '{3'h1, 8'h22, 1'b0, 8'h22}, '{3'h2, 8'h33, 1'b0, 8'h33},
    '{3'h3, 8'h44, 1'b0, 8'h44}, '{3'h4, 8'h55, 1'b0, 8'h55}, '{3'h5, 8'h66, 1'b0, 8'h66},
    '{3'h6, 8'h77, 1'b0, 8'h77}, '{3'h7, 8'h88, 1'b0, 8'h88}, '{3'h1, 8'hee, 1'b1, 8'h22}
  };

  always #25 sys_clk = ~sys_clk;

  stc_device stc_device_i (
    .sys_clk(sys_clk), .rstn(rstn), .cke(cke), .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]),
    .we_n(cmd[0]), .bank(bank), .addr(addr), .dq_in(dq_in), .dqm(dqm), .dq_out(dq_out),
    .dq_oe(dq_oe), .rd_copy_data(rd_copy_data), .rd_copy_valid(rd_copy_valid),
    .rd_copy_ready(rd_copy_ready), .pdown(pdown), .suspended(suspended),
    .self_refresh(self_refresh)
  );
  stc_ctrl_model stc_ctrl_model_i (
    .sys_clk(sys_clk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .addr(addr), .dq_in(dq_in), .dqm(dqm)
  );

  always @(posedge sys_clk) begin
    if (rd_copy_valid === 1'b1 && rd_copy_ready === 1'b1) got.push_back(rd_copy_data);
  end

  task automatic chkd(input string what, input logic [7:0] want, input logic [7:0] seen);
    n_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic chkf(input string what, input logic want, input logic seen);
    chkd(what, {7'h0, want}, {7'h0, seen});
  endtask
  task automatic chk_rst();
    chkd("dq_out", 8'h00, dq_out);
    chkf("dq_oe", 1'b0, dq_oe);
    chkf("rd_copy_valid", 1'b0, rd_copy_valid);
    chkf("pdown", 1'b0, pdown);
    chkf("suspended", 1'b0, suspended);
    chkf("self_refresh", 1'b0, self_refresh);
  endtask
  task automatic cyc(input int n);
    stc_ctrl_model_i.nop(n);
  endtask
  task automatic rd(input logic [12:0] a);
    stc_ctrl_model_i.send(stc_pkg::CMD_READ, a, 8'h0, 1'b0);
  endtask
  task automatic setmode(input logic [12:0] a);
    stc_ctrl_model_i.pre(13'h400);
    stc_ctrl_model_i.mode(a);
    stc_ctrl_model_i.act(13'h0);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk);
    n_mismatch++;
    $display("[ERR] run length expected under 4000 cycles seen more");
    final_report();
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    chk_rst();
    rstn = 1'b1;
    cyc(1);
    chk_rst();
    cyc(2000);
    stc_ctrl_model_i.refresh();
    stc_ctrl_model_i.refresh();
    setmode(13'h020);
    foreach (rows[i]) begin
      stc_ctrl_model_i.send(stc_pkg::CMD_WRITE, {10'h0, rows[i].col}, rows[i].wd, rows[i].mask);
      rd({10'h0, rows[i].col});
      cyc(1);
      chkd("single read", rows[i].want, dq_out);
      if (!rows[i].mask) mem[rows[i].col] = rows[i].wd;
    end
    setmode(13'h021);
    stc_ctrl_model_i.send(stc_pkg::CMD_WRITE, 13'h004, 8'haa, 1'b0);
    stc_ctrl_model_i.word(8'hbb, 1'b1);
    mem[4] = 8'haa;
    rd(13'h004);
    cyc(1);
    chkd("burst word 0", mem[4], dq_out);
    cyc(1);
    chkd("burst word 1", mem[5], dq_out);
    rd(13'h000);
    rd(13'h002);
    chkd("first cut burst", mem[0], dq_out);
    cyc(1);
    chkd("second burst 0", mem[2], dq_out);
    cyc(1);
    chkd("second burst 1", mem[3], dq_out);
    cyc(1);
    chkf("oe after bursts", 1'b0, dq_oe);
    setmode(13'h022);
    rd(13'h000);
    stc_ctrl_model_i.word(8'h00, 1'b1);
    chkf("oe before mask", 1'b1, dq_oe);
    cyc(1);
    chkf("oe masked", 1'b0, dq_oe);
    cyc(1);
    chkd("word after mask", mem[2], dq_out);
    cyc(2);
    for (int lat = 2; lat <= 3; lat++) begin
      setmode({6'h0, 3'(lat), 4'h3});
      rd(13'h000);
      cyc(1);
      stc_ctrl_model_i.pre(13'h000);
      chkf("oe at precharge", 1'b1, dq_oe);
      repeat (lat - 2) begin
        cyc(1);
        chkf("oe still driven", 1'b1, dq_oe);
      end
      cyc(1);
      chkf("oe floated", 1'b0, dq_oe);
      cyc(2);
    end
    // a stop one clock after the only write word leaves the next column untouched
    setmode(13'h022);
    stc_ctrl_model_i.send(stc_pkg::CMD_WRITE, 13'h006, 8'h99, 1'b0);
    stc_ctrl_model_i.send(stc_pkg::CMD_BSTOP, 13'h000, 8'h0, 1'b0);
    mem[6] = 8'h99;
    rd(13'h006);
    cyc(1);
    chkd("stopped burst 0", mem[6], dq_out);
    cyc(1);
    chkd("stopped burst 1", mem[7], dq_out);
    // precharge of another bank must not cut the burst; auto precharge closes the row
    rd(13'h400);
    bank = 2'h1;
    stc_ctrl_model_i.send(stc_pkg::CMD_PRE, 13'h000, 8'h0, 1'b0);
    bank = 2'h0;
    cyc(1);
    chkd("other bank pre 1", mem[1], dq_out);
    cyc(1);
    chkd("other bank pre 2", mem[2], dq_out);
    rd(13'h000);
    cyc(2);
    chkf("closed row read", 1'b0, dq_oe);
    setmode(13'h022);
    rd(13'h000);
    stc_ctrl_model_i.en(1'b0);
    cyc(1);
    chkd("word before gate", mem[0], dq_out);
    chkf("suspended", 1'b1, suspended);
    stc_ctrl_model_i.en(1'b1);
    cyc(1);
    chkd("held word", mem[0], dq_out);
    chkf("suspend cleared", 1'b0, suspended);
    cyc(1);
    chkd("resumed word", mem[1], dq_out);
    cyc(4);
    stc_ctrl_model_i.en(1'b0);
    cyc(2);
    chkf("pdown entry", 1'b1, pdown);
    stc_ctrl_model_i.en(1'b1);
    cyc(2);
    chkf("pdown exit", 1'b0, pdown);
    rd_copy_ready = 1'b0;
    got.delete();
    rd(13'h000);
    cyc(4);
    chkd("stalled dq", mem[1], dq_out);
    chkd("copy head", mem[0], rd_copy_data);
    rd_copy_ready = 1'b1;
    cyc(8);
    chkd("copy count", 8'h04, 8'(got.size()));
    foreach (got[k]) if (k < 4) chkd("copy word", mem[k], got[k]);
    stc_ctrl_model_i.pre(13'h400);
    stc_ctrl_model_i.en(1'b0);
    stc_ctrl_model_i.refresh();
    chkf("self refresh in", 1'b1, self_refresh);
    stc_ctrl_model_i.sr_exit();
    chkf("self refresh out", 1'b0, self_refresh);
    rstn = 1'b0;
    cyc(1);
    chk_rst();
    rstn = 1'b1;
    cyc(1);
    chk_rst();
    final_report();
  end
endmodule
